// ---- logic/sac_consts.svh ----
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

`define SAC_ADDR_SCR      3'h0
`define SAC_ADDR_CFG      3'h1
`define SAC_ADDR_RESH     3'h2
`define SAC_ADDR_RESL     3'h3

`define SAC_SCR_FLAG      7
`define SAC_SCR_IE        6
`define SAC_SCR_CONT      5
`define SAC_SCR_CH_HI     4

`define SAC_CFG_LP        7
`define SAC_CFG_DIV_HI    6
`define SAC_CFG_DIV_LO    5
`define SAC_CFG_LSMP      4
`define SAC_CFG_MODE10    3
`define SAC_CFG_ICLK      2
`define SAC_CFG_ACLK      1

`define SAC_SCR_RESET     8'h1F
`define SAC_CFG_RESET     8'h00
`define SAC_CHANNEL_OFF   5'h1F

`define SAC_SAMPLE_SHORT  5'h03
`define SAC_SAMPLE_LONG   5'h17
`define SAC_SETTLE        2'h3
`define SAC_FIRST_TRIAL   10'h200
`define SAC_FIRST_BIT     4'h9
`define SAC_FULL_8BIT     8'hFF
`define SAC_ROUND_ADD     11'h002
`define SAC_BUS_STEP      4'h1
`define SAC_ALT_STEP      4'h4

`endif

// ---- logic/sac_pkg.sv ----
// Types of the converter control
package sac_pkg;

   typedef enum logic [2:0] {
      SAC_IDLE   = 3'b001,
      SAC_SAMPLE = 3'b010,
      SAC_TRIAL  = 3'b100
   } sac_phase_type;

   typedef struct packed {
      sac_phase_type phase;
      logic          irqEnable;
      logic          continuous;
      logic [4:0]    channel;
      logic [7:0]    cfg;
      logic [1:0]    resultHigh;
      logic [7:0]    resultLow;
      logic          completeFlag;
      logic          highReadPending;
      logic [9:0]    sar;
      logic [3:0]    bitPtr;
      logic [4:0]    tickCount;
      logic [1:0]    settle;
      logic [7:0]    readData;
      logic          compSync1;
      logic          compSync2;
   } sac_ctrl_state_type;

   typedef struct packed {
      logic       oscSync1;
      logic       oscSync2;
      logic       oscPrev;
      logic [3:0] acc;
   } sac_div_state_type;

endpackage : sac_pkg

// ---- logic/sac_clock_divider.sv ----
// Clock select and divide: turns the chosen source into converter clock ticks
`timescale 1ns/100ps
`include "sac_consts.svh"

module sac_clock_divider
   import sac_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       run,
   input  wire logic       asyncClockSelect,
   input  wire logic       inputClockSelect,
   input  wire logic [1:0] clockDivideField,
   input  wire logic       asyncOscIn,
   output logic            asyncOscEnable,
   output logic            adckTick
);

   sac_div_state_type st;
   sac_div_state_type next_st;

   always_comb begin
      logic [3:0] step;
      logic [4:0] total;
      logic [4:0] divisor;
      logic [4:0] rem;
      step    = 4'h0;
      total   = 5'h00;
      divisor = 5'h01 << clockDivideField;
      rem     = 5'h00;
      next_st = st;
      adckTick = 1'b0;
      next_st.oscSync1 = asyncOscIn;
      next_st.oscSync2 = st.oscSync1;
      next_st.oscPrev  = st.oscSync2;
      // Async source counts its own rising edges; alternate source is four per bus cycle
      if (asyncClockSelect) begin
         step = (st.oscSync2 && !st.oscPrev) ? 4'h1 : 4'h0;
      end else if (inputClockSelect) begin
         step = `SAC_BUS_STEP;
      end else begin
         step = `SAC_ALT_STEP;
      end
      total = {1'b0, st.acc} + {1'b0, step};
      if (!run) begin
         next_st.acc = 4'h0;
      end else if (total >= divisor) begin
         adckTick = 1'b1;
         rem = total - divisor;
         // At most one tick per bus cycle; faster ratios saturate here
         next_st.acc = (rem >= divisor) ? 4'(divisor - 5'h01) : rem[3:0];
      end else begin
         next_st.acc = total[3:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Oscillator runs only while converting with the dedicated clock selected
   assign asyncOscEnable = run && asyncClockSelect;

endmodule : sac_clock_divider

// ---- logic/sac_sar_control.sv ----
// Successive-approximation converter control with register port and result formatting
`timescale 1ns/100ps
`include "sac_consts.svh"

module sac_sar_control
   import sac_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [2:0] busAddr,
   input  wire logic [7:0] busWriteData,
   input  wire logic       busWrite,
   input  wire logic       busRead,
   output logic      [7:0] busReadData,
   input  wire logic       muxedAnalogCompare,
   input  wire logic       asyncOscIn,
   output logic      [9:0] trialCode,
   output logic            sampleEnable,
   output logic            converterPowerUp,
   output logic      [4:0] channelSelectField,
   output logic            asyncOscEnable,
   output logic            lowPowerConfig,
   output logic            conversionIrq
);

   sac_ctrl_state_type st;
   sac_ctrl_state_type next_st;

   logic       adckTick;
   logic       abortNow;
   logic       transferNow;
   logic       blocked;
   logic [9:0] finalCode;

   sac_clock_divider u_divider (
      .clk              (clk),
      .resetn           (resetn),
      .run              (st.phase != SAC_IDLE),
      .asyncClockSelect (st.cfg[`SAC_CFG_ACLK]),
      .inputClockSelect (st.cfg[`SAC_CFG_ICLK]),
      .clockDivideField (st.cfg[`SAC_CFG_DIV_HI:`SAC_CFG_DIV_LO]),
      .asyncOscIn       (asyncOscIn),
      .asyncOscEnable   (asyncOscEnable),
      .adckTick         (adckTick)
   );

   always_comb begin
      logic [9:0]  mask;
      logic [10:0] roundSum;
      logic [7:0]  rounded;
      logic        setFlag;
      logic        clearFlag;
      logic [4:0]  sampleLoad;
      mask       = 10'h001 << st.bitPtr;
      roundSum   = 11'h000;
      rounded    = 8'h00;
      setFlag    = 1'b0;
      clearFlag  = 1'b0;
      sampleLoad = st.cfg[`SAC_CFG_LSMP] ? `SAC_SAMPLE_LONG : `SAC_SAMPLE_SHORT;
      next_st    = st;
      next_st.compSync1 = muxedAnalogCompare;
      next_st.compSync2 = st.compSync1;
      next_st.readData  = 8'h00;

      abortNow = busWrite && (busAddr == `SAC_ADDR_SCR || busAddr == `SAC_ADDR_CFG);
      transferNow = 1'b0;
      // Keep the trial bit when the input is at or above the trial level
      finalCode = st.compSync2 ? st.sar : (st.sar & ~mask);
      blocked = st.cfg[`SAC_CFG_MODE10] && st.highReadPending;

      case (st.phase)
         SAC_IDLE: begin
         end
         SAC_SAMPLE: begin
            if (adckTick && !abortNow) begin
               if (st.tickCount == 5'h00) begin
                  next_st.phase  = SAC_TRIAL;
                  next_st.sar    = `SAC_FIRST_TRIAL;
                  next_st.bitPtr = `SAC_FIRST_BIT;
                  next_st.settle = `SAC_SETTLE;
               end else begin
                  next_st.tickCount = st.tickCount - 5'h01;
               end
            end
         end
         SAC_TRIAL: begin
            // Settle covers the two-stage comparator synchroniser
            if (st.settle != 2'h0) begin
               next_st.settle = st.settle - 2'h1;
            end else if (adckTick && !abortNow) begin
               if (st.bitPtr != 4'h0) begin
                  next_st.sar    = finalCode | (mask >> 1);
                  next_st.bitPtr = st.bitPtr - 4'h1;
                  next_st.settle = `SAC_SETTLE;
               end else begin
                  transferNow = 1'b1;
               end
            end
         end
         default: begin
            next_st.phase = SAC_IDLE;
         end
      endcase

      // Completion is produced on the bus clock, so the event needs no further crossing
      if (transferNow) begin
         next_st.sar = finalCode;
         if (!blocked) begin
            if (st.cfg[`SAC_CFG_MODE10]) begin
               next_st.resultHigh = finalCode[9:8];
               next_st.resultLow  = finalCode[7:0];
            end else begin
               roundSum = {1'b0, finalCode} + `SAC_ROUND_ADD;
               rounded  = roundSum[10] ? `SAC_FULL_8BIT : roundSum[9:2];
               next_st.resultHigh = 2'b00;
               next_st.resultLow  = rounded;
            end
            setFlag = 1'b1;
         end
         // A blocked transfer discards the result and converts again
         if (blocked || st.continuous) begin
            next_st.phase     = SAC_SAMPLE;
            next_st.tickCount = sampleLoad;
         end else begin
            next_st.phase = SAC_IDLE;
         end
      end

      if (busRead) begin
         case (busAddr)
            `SAC_ADDR_SCR: begin
               next_st.readData = {st.completeFlag, st.irqEnable, st.continuous, st.channel};
            end
            `SAC_ADDR_CFG: begin
               next_st.readData = st.cfg;
            end
            `SAC_ADDR_RESH: begin
               next_st.readData = {6'h00, st.resultHigh};
               if (st.cfg[`SAC_CFG_MODE10]) begin
                  next_st.highReadPending = 1'b1;
               end
            end
            `SAC_ADDR_RESL: begin
               next_st.readData = st.resultLow;
               next_st.highReadPending = 1'b0;
               clearFlag = 1'b1;
            end
            default: begin
               next_st.readData = 8'h00;
            end
         endcase
      end

      // Only software writes start conversions; there is no hardware trigger
      if (busWrite) begin
         case (busAddr)
            `SAC_ADDR_SCR: begin
               next_st.irqEnable  = busWriteData[`SAC_SCR_IE];
               next_st.continuous = busWriteData[`SAC_SCR_CONT];
               next_st.channel    = busWriteData[`SAC_SCR_CH_HI:0];
               clearFlag = 1'b1;
               if (busWriteData[`SAC_SCR_CH_HI:0] != `SAC_CHANNEL_OFF) begin
                  next_st.phase     = SAC_SAMPLE;
                  next_st.tickCount = sampleLoad;
               end else begin
                  next_st.phase = SAC_IDLE;
               end
            end
            `SAC_ADDR_CFG: begin
               next_st.cfg   = busWriteData;
               next_st.phase = SAC_IDLE;
            end
            default: begin
            end
         endcase
      end

      // A completion in the same cycle as a clear keeps the flag set
      next_st.completeFlag = setFlag || (st.completeFlag && !clearFlag);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st                 <= '0;
         st.phase           <= SAC_IDLE;
         st.channel         <= `SAC_CHANNEL_OFF;
         st.cfg             <= `SAC_CFG_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign busReadData        = st.readData;
   assign trialCode          = st.sar;
   assign sampleEnable       = (st.phase == SAC_SAMPLE);
   assign converterPowerUp   = (st.phase != SAC_IDLE);
   assign channelSelectField = st.channel;
   assign lowPowerConfig     = st.cfg[`SAC_CFG_LP];
   assign conversionIrq      = st.completeFlag && st.irqEnable;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   chk_single_power_down: assert property (
      transferNow && !blocked && !st.continuous && !abortNow |=> !converterPowerUp)
      else $error("single conversion did not power down");

   chk_continuous_restart: assert property (
      transferNow && st.continuous && !abortNow |=> sampleEnable)
      else $error("continuous mode did not restart");

   chk_flag_after_transfer: assert property (
      transferNow && !blocked |=> st.completeFlag)
      else $error("flag not set after result transfer");

   chk_irq_gated: assert property (
      transferNow && !blocked |=> conversionIrq == $past(st.irqEnable))
      else $error("interrupt does not follow its enable");

   chk_full_scale_8bit: assert property (
      transferNow && !blocked && !st.cfg[`SAC_CFG_MODE10] && finalCode == 10'h3FF
      |=> st.resultLow == 8'hFF && st.resultHigh == 2'b00)
      else $error("eight-bit full scale is not all ones");

   chk_ten_bit_split: assert property (
      transferNow && !blocked && st.cfg[`SAC_CFG_MODE10]
      |=> {st.resultHigh, st.resultLow} == $past(finalCode))
      else $error("ten-bit result not split into bytes");

   chk_write_starts: assert property (
      busWrite && busAddr == `SAC_ADDR_SCR && busWriteData[4:0] != 5'h1F
      |=> sampleEnable && st.tickCount inside {5'h03, 5'h17})
      else $error("control write did not start a conversion");

   chk_clock_write_aborts: assert property (
      busWrite && busAddr == `SAC_ADDR_CFG
      |=> !converterPowerUp ##1 (!converterPowerUp || $past(busWrite)))
      else $error("clock write did not abort");

   chk_async_only_busy: assert property (
      asyncOscEnable |-> converterPowerUp && st.cfg[`SAC_CFG_ACLK])
      else $error("async clock enabled while idle");

   chk_read_latency: assert property (
      busRead && busAddr == `SAC_ADDR_RESL && !busWrite |=> busReadData == $past(st.resultLow))
      else $error("result low byte read wrong");

   chk_read_idle_zero: assert property (
      !busRead |=> busReadData == 8'h00)
      else $error("read data stands longer than one cycle");

   chk_blocked_discards: assert property (
      transferNow && blocked |=> $stable({st.resultHigh, st.resultLow}) && sampleEnable)
      else $error("blocked transfer changed the results");

   chk_eight_bit_high: assert property (
      transferNow && !blocked && !st.cfg[`SAC_CFG_MODE10] |=> st.resultHigh == 2'h0)
      else $error("eight-bit result left bits in the high byte");

   chk_zero_code: assert property (
      transferNow && !blocked && finalCode == 10'h000
      |=> st.resultHigh == 2'h0 && st.resultLow == 8'h00)
      else $error("zero input did not give a zero result");

   chk_full_scale_10bit: assert property (
      transferNow && !blocked && st.cfg[`SAC_CFG_MODE10] && finalCode == 10'h3FF
      |=> st.resultHigh == 2'h3 && st.resultLow == 8'hFF)
      else $error("ten-bit full scale is not all ones");

   chk_channel_held: assert property (
      converterPowerUp && !busWrite |=> $stable(channelSelectField))
      else $error("channel changed during a conversion");

   chk_abort_keeps_results: assert property (
      abortNow |=> $stable({st.resultHigh, st.resultLow}))
      else $error("abort altered the result registers");

   chk_no_self_start: assert property (
      !converterPowerUp && !busWrite |=> !converterPowerUp)
      else $error("conversion started without a software write");

   chk_off_channel_idles: assert property (
      busWrite && busAddr == `SAC_ADDR_SCR && busWriteData[4:0] == `SAC_CHANNEL_OFF
      |=> !converterPowerUp)
      else $error("write with channel off started a conversion");

   chk_flag_cleared_by_write: assert property (
      busWrite && busAddr == `SAC_ADDR_SCR |=> !st.completeFlag)
      else $error("control write did not clear the flag");

   chk_tick_only_busy: assert property (
      !converterPowerUp |-> !adckTick)
      else $error("converter clock ticked while idle");

   chk_bus_undivided: assert property (
      converterPowerUp && !st.cfg[`SAC_CFG_ACLK] && st.cfg[`SAC_CFG_ICLK]
      && st.cfg[`SAC_CFG_DIV_HI:`SAC_CFG_DIV_LO] == 2'h0 |-> adckTick)
      else $error("undivided bus clock missed a tick");

   chk_alternate_fast: assert property (
      converterPowerUp && !st.cfg[`SAC_CFG_ACLK] && !st.cfg[`SAC_CFG_ICLK]
      && st.cfg[`SAC_CFG_DIV_HI:`SAC_CFG_DIV_LO] != 2'h3 |-> adckTick)
      else $error("alternate clock ticked slower than expected");

   chk_trial_start: assert property (
      sampleEnable ##1 (converterPowerUp && !sampleEnable) |-> trialCode == `SAC_FIRST_TRIAL)
      else $error("trial phase did not start from the middle code");

   chk_low_power_source: assert property (
      $changed(lowPowerConfig) |-> ($past(busWrite) && $past(busAddr) == `SAC_ADDR_CFG)
      || !$past(resetn))
      else $error("low-power output changed without a clock write");

   chk_async_spacing: assert property (
      adckTick && st.cfg[`SAC_CFG_ACLK] |=> !adckTick)
      else $error("dedicated clock ticks faster than its edges");

   cov_single_done: cover property (transferNow && !blocked && !st.continuous);
   cov_continuous: cover property (transferNow && st.continuous ##[1:200] transferNow);
   cov_blocked: cover property (transferNow && blocked);
   cov_abort_busy: cover property (converterPowerUp && abortNow);

endmodule : sac_sar_control

// ---- bench/sac_analog_front.sv ----
// Behavioural analog front end: channel levels, comparator and dedicated oscillator
`timescale 1ns/100ps

module sac_analog_front (
   input  wire logic [9:0] trialCode,
   input  wire logic       sampleEnable,
   input  wire logic [4:0] channelSelectField,
   input  wire logic       asyncOscEnable,
   input  wire logic       lowPowerConfig,
   output logic            muxedAnalogCompare,
   output logic            asyncOscIn
);
   // Levels in code units; 11'h400 and above sits at or over the high reference
   logic [10:0] levelTable [0:31];
   logic [10:0] heldLevel;

   initial begin
      heldLevel = 11'h000;
      for (int i = 0; i < 32; i++) begin
         levelTable[i] = 11'h000;
      end
   end

   // Only the selected channel is captured while sampling
   always @(sampleEnable or channelSelectField) begin
      if (sampleEnable) begin
         heldLevel = levelTable[channelSelectField];
      end
   end

   // Anything over the high reference compares high for every trial code
   assign muxedAnalogCompare = (heldLevel >= {1'b0, trialCode});

   // Runs only while enabled, halved rate in low power, no stop input gates it
   initial begin
      asyncOscIn = 1'b0;
      forever begin
         if (asyncOscEnable) begin
            #(lowPowerConfig ? 660 : 330);
            asyncOscIn = ~asyncOscIn;
         end else begin
            asyncOscIn = 1'b0;
            wait (asyncOscEnable);
         end
      end
   end
endmodule : sac_analog_front

// ---- bench/tb.sv ----
// Self-checking testbench of the converter control
`timescale 1ns/100ps
`include "sac_consts.svh"

module tb;
   logic       clk;
   logic       resetn;
   logic [2:0] busAddr;
   logic [7:0] busWriteData;
   logic       busWrite;
   logic       busRead;
   logic [7:0] busReadData;
   logic       muxedAnalogCompare;
   logic       asyncOscIn;
   logic [9:0] trialCode;
   logic       sampleEnable;
   logic       converterPowerUp;
   logic [4:0] channelSelectField;
   logic       asyncOscEnable;
   logic       lowPowerConfig;
   logic       conversionIrq;
   int         err_total;
   int         num_checks;
   int         cyc [0:5];
   logic [7:0] cfgList [0:5] = '{8'h0C, 8'h6C, 8'h08, 8'h68, 8'h0A, 8'h8A};
   logic [10:0] lvlList [0:2] = '{11'h000, 11'h2A5, 11'h400};
   logic [9:0]  e10List [0:2] = '{10'h000, 10'h2A5, 10'h3FF};
   logic [7:0]  e8List  [0:2] = '{8'h00, 8'hA9, 8'hFF};
   int         n;

   sac_sar_control sac_sar_control_inst (
      .clk(clk), .resetn(resetn), .busAddr(busAddr), .busWriteData(busWriteData),
      .busWrite(busWrite), .busRead(busRead), .busReadData(busReadData),
      .muxedAnalogCompare(muxedAnalogCompare), .asyncOscIn(asyncOscIn),
      .trialCode(trialCode), .sampleEnable(sampleEnable),
      .converterPowerUp(converterPowerUp), .channelSelectField(channelSelectField),
      .asyncOscEnable(asyncOscEnable), .lowPowerConfig(lowPowerConfig),
      .conversionIrq(conversionIrq));

   sac_analog_front sac_analog_front_inst (
      .trialCode(trialCode), .sampleEnable(sampleEnable),
      .channelSelectField(channelSelectField), .asyncOscEnable(asyncOscEnable),
      .lowPowerConfig(lowPowerConfig), .muxedAnalogCompare(muxedAnalogCompare),
      .asyncOscIn(asyncOscIn));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      busAddr      <= a;
      busWriteData <= d;
      busWrite     <= 1'b1;
      @(posedge clk);
      busWrite <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      busAddr <= a;
      busRead <= 1'b1;
      @(posedge clk);
      busRead <= 1'b0;
      #1 d = busReadData;
   endtask : rd

   task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input string name);
      logic [7:0] d;
      rd(a, d);
      check(name, {4'h0, exp}, {4'h0, d});
   endtask : rchk

   // Polls the flag; a run-out counts as a mismatch and ends the run
   task automatic conv(input logic [7:0] cfg, input logic [7:0] scr, input logic [10:0] lvl,
                       output int polls);
      logic [7:0] d;
      sac_analog_front_inst.levelTable[scr[4:0]] = lvl;
      wr(`SAC_ADDR_CFG, cfg);
      wr(`SAC_ADDR_SCR, scr);
      @(posedge clk);
      #1 check("osc enable", {11'h0, cfg[`SAC_CFG_ACLK]}, {11'h0, asyncOscEnable});
      polls = 0;
      d = 8'h00;
      while (d[`SAC_SCR_FLAG] !== 1'b1 && polls < 3000) begin
         rd(`SAC_ADDR_SCR, d);
         polls++;
      end
      if (d[`SAC_SCR_FLAG] !== 1'b1) begin
         check("completion timeout", 12'h001, 12'h000);
         close_out();
      end
   endtask : conv

   initial begin
      resetn = 1'b0;
      busAddr = 3'h0;
      busWriteData = 8'h00;
      busWrite = 1'b0;
      busRead = 1'b0;
      err_total = 0;
      num_checks = 0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      rchk(`SAC_ADDR_SCR, `SAC_SCR_RESET, "scr reset");
      rchk(`SAC_ADDR_CFG, `SAC_CFG_RESET, "cfg reset");
      rchk(3'h5, 8'h00, "unmapped read");
      wr(`SAC_ADDR_RESL, 8'hAA);
      rchk(`SAC_ADDR_RESL, 8'h00, "result low read-only");
      check("idle without trigger", 12'h000, {11'h0, converterPowerUp});
      for (int i = 0; i < 3; i++) begin
         conv(8'h0C, 8'(i * 3), lvlList[i], n);
         check("single powers down", 12'h000, {11'h0, converterPowerUp});
         check("final trial code", {2'h0, e10List[i]}, {2'h0, trialCode});
         rchk(`SAC_ADDR_RESH, {6'h0, e10List[i][9:8]}, "ten-bit high");
         rchk(`SAC_ADDR_RESL, e10List[i][7:0], "ten-bit low");
         conv(8'h04, 8'(i * 3 + 1), lvlList[i], n);
         rchk(`SAC_ADDR_RESH, 8'h00, "eight-bit high");
         rchk(`SAC_ADDR_RESL, e8List[i], "eight-bit low");
      end
      // Bus, alternate and dedicated sources, each at two divide or rate settings
      for (int i = 0; i < 6; i++) begin
         conv(cfgList[i], 8'h03, 11'h155, cyc[i]);
         rchk(`SAC_ADDR_RESH, 8'h01, "source high");
         rchk(`SAC_ADDR_RESL, 8'h55, "source low");
         check("low power", {11'h0, cfgList[i][`SAC_CFG_LP]}, {11'h0, lowPowerConfig});
      end
      check("bus divide slows", 12'h001, {11'h0, cyc[1] > cyc[0]});
      check("alternate divide slows", 12'h001, {11'h0, cyc[3] > cyc[2]});
      check("low power halves rate", 12'h001, {11'h0, cyc[5] > cyc[4]});
      conv(8'h0C, 8'h45, 11'h3FF, n);
      check("irq enabled", 12'h001, {11'h0, conversionIrq});
      rchk(`SAC_ADDR_RESH, 8'h03, "irq high");
      rchk(`SAC_ADDR_RESL, 8'hFF, "irq low");
      check("irq cleared", 12'h000, {11'h0, conversionIrq});
      conv(8'h0C, 8'h05, 11'h3FF, n);
      check("irq masked", 12'h000, {11'h0, conversionIrq});
      conv(8'h0C, 8'h24, 11'h0F0, n);
      rchk(`SAC_ADDR_RESH, 8'h00, "cont high");
      rchk(`SAC_ADDR_RESL, 8'hF0, "cont first");
      sac_analog_front_inst.levelTable[4] = 11'h0F1;
      repeat (200) @(posedge clk);
      rchk(`SAC_ADDR_SCR, 8'hA4, "cont restarts");
      rchk(`SAC_ADDR_RESH, 8'h00, "cont high again");
      rchk(`SAC_ADDR_RESL, 8'hF1, "cont second");
      wr(`SAC_ADDR_SCR, `SAC_SCR_RESET);
      @(posedge clk);
      #1 check("channel off idles", 12'h000, {11'h0, converterPowerUp});
      check("channel off field", 12'h01F, {7'h0, channelSelectField});
      sac_analog_front_inst.levelTable[2] = 11'h111;
      wr(`SAC_ADDR_SCR, 8'h02);
      @(posedge clk);
      #1 check("start samples", 12'h001, {11'h0, sampleEnable});
      wr(`SAC_ADDR_CFG, 8'h0C);
      @(posedge clk);
      #1 check("cfg write aborts", 12'h000, {11'h0, converterPowerUp});
      repeat (100) @(posedge clk);
      rchk(`SAC_ADDR_SCR, 8'h02, "abort no flag");
      rchk(`SAC_ADDR_RESH, 8'h00, "abort keeps high");
      rchk(`SAC_ADDR_RESL, 8'hF1, "abort keeps low");
      // Reset in the middle of a conversion
      wr(`SAC_ADDR_SCR, 8'h02);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      #1 check("reset aborts", 12'h000, {11'h0, converterPowerUp});
      rchk(`SAC_ADDR_RESL, 8'h00, "reset clears low");
      rchk(`SAC_ADDR_SCR, `SAC_SCR_RESET, "reset clears scr");
      close_out();
   end
endmodule : tb
